// ==== hdl/pin_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] stage_one_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			stage_one_reg <= RESET_VAL;
			pin_sync_out <= RESET_VAL;
		end else begin
			stage_one_reg <= pin_in;
			pin_sync_out <= stage_one_reg;
		end
	end

endmodule : pin_sync

// ==== hdl/smm_control.sv ====
// system management mode control: config registers, strobe choice, entry and resume
// Operation
// - resume loads ip from the next-ip word at base plus size minus 14h.
// - resume restores only cs, next ip, eflags, cr0 and dr7.
// - during smi, overlap access set sends non-cs data accesses in smm space to normal strobe.
// - during smi, code fetches in smm space always use the smm strobe.
// - on entry cs base is region base, eip zero, cs limit region size minus one.
// - line twenty mask is ignored for every smm strobe access.
// - smm instructions allowed outside region when access enable set or smi active; code also needs cpl zero, and smi enable with a valid region for access enable.
// - handler is in progress exactly while the device drives the smi line low.
// - entry leaves nmi as only enabled interrupt, maskable interrupts off.
// - entry keeps the interrupt table definition, no reset to 0:0.
// - smm strobe accesses are never cached.
// - above 1m the cs selector keeps only 16 bits, base holds all.
// - smm instruction under wrong conditions raises undefined opcode.
// - cs limit is enforced and real-mode jumps leave it unchanged.
// - entry leaves the other segment limits untouched.
// - config bit 1 enables smi input, bit 7 makes region 4 smm space.
// - range register holds base above bit 3 and size in bits 3-0.
// - registers reached by index at port 22h and data at port 23h.
// - config bit 2 lets normal mode use smm strobe inside the region.
// - after recognising smi the line is held low until resume.
`timescale 1ns/1ps
`include "smm_ctrl_regs.svh"
module smm_control import smm_ctrl_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// configuration i/o access
	input wire logic io_req,
	input wire logic io_write,
	input wire logic [15:0] io_port,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_ack,
	// memory access request and bus strobes
	input wire mem_req_t mem_req,
	output logic smm_address_strobe_b,
	output logic normal_address_strobe_b,
	output logic [31:0] bus_addr,
	output logic cache_bypass,
	// pins from and to the chipset
	input wire logic gate_line_twenty_mask_b,
	input wire logic mgmt_interrupt_line_in_b,
	output logic mgmt_interrupt_line_out,
	output logic mgmt_interrupt_line_oe,
	// core state and instruction events
	input wire logic cpl_zero,
	input wire logic smm_instr_attempt,
	input wire logic resume_from_mgmt,
	input wire logic [31:0] eip_now,
	input wire logic eip_check,
	input wire logic limit_write,
	input wire logic limit_write_real_mode,
	input wire logic [31:0] limit_write_value,
	// results to the core
	output seg_load_t entry_load,
	output resume_load_t resume_load,
	output logic maskable_int_disable,
	output logic nmi_only_enable,
	output logic undefined_opcode,
	output logic cs_limit_fault,
	output logic smi_in_progress
);

	logic [7:0] io_index_reg;
	logic [7:0] config_control_one;
	logic [15:0] region4_range_reg;
	logic [31:0] cs_limit_reg;
	smm_state_t state_reg;
	smm_state_t state_next;
	logic [1:0] pins_synced;
	logic smi_pin_low;
	logic gate_mask_low;
	logic smi_enable;
	logic smm_access_enable;
	logic main_memory_overlap_access;
	logic region4_smm_select;
	logic [31:0] smm_region_base;
	logic [31:0] smm_region_bytes;
	logic region_valid;
	logic addr_hit;
	logic use_smm_strobe;
	logic instr_permitted;
	logic handler_active;
	logic smi_armed_reg;

	// size code to bytes: 1 is 4kb, doubling up to 16mb, 0 is no region
	function automatic logic [31:0] size_bytes(input logic [3:0] code);
		logic [3:0] capped;
		capped = (code > `RANGE_SIZE_MAX_CODE) ? `RANGE_SIZE_MAX_CODE : code;
		if (code == 4'h0) begin
			size_bytes = 32'h0000_0000;
		end else begin
			size_bytes = `RANGE_MIN_BYTES << (capped - 4'h1);
		end
	endfunction : size_bytes

	// address inside [base, base + size)
	function automatic logic in_region(input logic [31:0] addr, input logic [31:0] base,
		input logic [31:0] bytes);
		in_region = (bytes != 32'h0000_0000) && (addr >= base) && ((addr - base) < bytes);
	endfunction : in_region

	pin_sync #(
		.WIDTH(2),
		.RESET_VAL(2'b11)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin_in({mgmt_interrupt_line_in_b, gate_line_twenty_mask_b}),
		.pin_sync_out(pins_synced)
	);

	assign smi_pin_low = !pins_synced[1];
	assign gate_mask_low = !pins_synced[0];

	// configuration fields
	assign smi_enable = config_control_one[`CCR_SMI_ENABLE_BIT];
	assign region4_smm_select = config_control_one[`CCR_REGION4_SMM_BIT];
	assign smm_access_enable = config_control_one[`CCR_SMM_ACCESS_BIT];
	assign main_memory_overlap_access = config_control_one[`CCR_OVERLAP_BIT];
	assign smm_region_base = {8'h00, region4_range_reg[`RANGE_BASE_HI:`RANGE_BASE_LO], 12'h000};
	assign smm_region_bytes = size_bytes(region4_range_reg[`RANGE_SIZE_HI:`RANGE_SIZE_LO]);
	assign region_valid = region4_smm_select && (smm_region_bytes != 32'h0000_0000);

	// in progress exactly while the line is driven low
	assign handler_active = (state_reg == ST_ENTRY) || (state_reg == ST_HANDLER) || (state_reg == ST_RESUME);
	assign smi_in_progress = handler_active;

	// index register at 22h
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			io_index_reg <= `IO_INDEX_RESET;
		end else if (io_req && io_write && io_port == `IO_INDEX_PORT) begin
			io_index_reg <= io_wdata;
		end
	end

	// indexed data writes at 23h
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			config_control_one <= `CONFIG_CONTROL_ONE_RESET;
			region4_range_reg <= `REGION4_RANGE_RESET;
		end else if (io_req && io_write && io_port == `IO_DATA_PORT) begin
			case (io_index_reg)
				`IDX_CONFIG_CONTROL_ONE: begin
					config_control_one <= io_wdata;
				end
				`IDX_REGION4_HIGH: begin
					region4_range_reg[15:8] <= io_wdata;
				end
				`IDX_REGION4_LOW: begin
					region4_range_reg[7:0] <= io_wdata;
				end
				default: begin
					config_control_one <= config_control_one;
				end
			endcase
		end
	end

	// read data and acknowledge
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			io_rdata <= 8'h00;
			io_ack <= 1'b0;
		end else begin
			io_ack <= io_req && (io_port == `IO_INDEX_PORT || io_port == `IO_DATA_PORT);
			if (io_req && !io_write && io_port == `IO_DATA_PORT) begin
				case (io_index_reg)
					`IDX_CONFIG_CONTROL_ONE: begin
						io_rdata <= config_control_one;
					end
					`IDX_REGION4_HIGH: begin
						io_rdata <= region4_range_reg[15:8];
					end
					`IDX_REGION4_LOW: begin
						io_rdata <= region4_range_reg[7:0];
					end
					default: begin
						io_rdata <= 8'h00;
					end
				endcase
			end else if (io_req && !io_write && io_port == `IO_INDEX_PORT) begin
				io_rdata <= io_index_reg;
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end

	// smi sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (smi_enable && smi_pin_low && region_valid && smi_armed_reg) begin
					state_next = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				state_next = ST_HANDLER;
			end
			ST_HANDLER: begin
				if (resume_from_mgmt) begin
					state_next = ST_RESUME;
				end
			end
			ST_RESUME: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// own low drive lingers in the synchroniser after release; wait for a high level first
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			smi_armed_reg <= 1'b0;
		end else if (state_next == ST_ENTRY && state_reg == ST_IDLE) begin
			smi_armed_reg <= 1'b0;
		end else if (!smi_pin_low) begin
			smi_armed_reg <= 1'b1;
		end
	end

	// line driven low from recognition until resume has run
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			mgmt_interrupt_line_oe <= 1'b0;
			mgmt_interrupt_line_out <= 1'b1;
		end else begin
			mgmt_interrupt_line_oe <= (state_next != ST_IDLE);
			mgmt_interrupt_line_out <= (state_next == ST_IDLE);
		end
	end

	// segment state on entry; other segment limits and the idt are not touched
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			entry_load <= '0;
		end else begin
			entry_load.load <= (state_next == ST_ENTRY) && (state_reg == ST_IDLE);
			if (state_next == ST_ENTRY && state_reg == ST_IDLE) begin
				entry_load.cs_base <= smm_region_base;
				entry_load.eip <= `ENTRY_EIP;
				entry_load.cs_limit <= smm_region_bytes - 32'h0000_0001;
				entry_load.cs_selector <= smm_region_base[19:4];
			end
		end
	end

	// interrupt enables at entry; nmi blocking during the handler is external
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			maskable_int_disable <= 1'b0;
			nmi_only_enable <= 1'b0;
		end else begin
			maskable_int_disable <= (state_next == ST_ENTRY) && (state_reg == ST_IDLE);
			nmi_only_enable <= (state_next == ST_ENTRY) && (state_reg == ST_IDLE);
		end
	end

	// resume: next ip from the header, only the five saved registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			resume_load <= '0;
		end else begin
			resume_load.load <= (state_next == ST_RESUME) && (state_reg == ST_HANDLER);
			resume_load.restore_cs <= (state_next == ST_RESUME) && (state_reg == ST_HANDLER);
			resume_load.restore_eflags <= (state_next == ST_RESUME) && (state_reg == ST_HANDLER);
			resume_load.restore_cr0 <= (state_next == ST_RESUME) && (state_reg == ST_HANDLER);
			resume_load.restore_dr7 <= (state_next == ST_RESUME) && (state_reg == ST_HANDLER);
			if (state_next == ST_RESUME && state_reg == ST_HANDLER) begin
				resume_load.next_ip_addr <= smm_region_base + smm_region_bytes - `NEXT_IP_OFFSET;
			end
		end
	end

	// cs limit: set at entry, changed only by non-real-mode loads
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cs_limit_reg <= 32'hFFFF_FFFF;
		end else if (state_next == ST_ENTRY && state_reg == ST_IDLE) begin
			cs_limit_reg <= smm_region_bytes - 32'h0000_0001;
		end else if (limit_write && !limit_write_real_mode) begin
			cs_limit_reg <= limit_write_value;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cs_limit_fault <= 1'b0;
		end else begin
			cs_limit_fault <= eip_check && handler_active && (eip_now > cs_limit_reg);
		end
	end

	// smm instruction permission
	assign instr_permitted = cpl_zero && (handler_active || (smm_access_enable && smi_enable && region_valid));

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			undefined_opcode <= 1'b0;
		end else begin
			undefined_opcode <= smm_instr_attempt && !instr_permitted;
		end
	end

	// strobe selection
	assign addr_hit = region_valid && in_region(mem_req.addr, smm_region_base, smm_region_bytes);

	always_comb begin
		use_smm_strobe = 1'b0;
		if (addr_hit) begin
			if (handler_active) begin
				if (mem_req.is_code || mem_req.cs_prefix) begin
					use_smm_strobe = 1'b1;
				end else begin
					use_smm_strobe = !main_memory_overlap_access;
				end
			end else begin
				use_smm_strobe = smm_access_enable;
			end
		end
	end

	// one strobe per request, smm accesses uncached and unmasked
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			smm_address_strobe_b <= 1'b1;
			normal_address_strobe_b <= 1'b1;
			cache_bypass <= 1'b0;
			bus_addr <= 32'h0000_0000;
		end else begin
			smm_address_strobe_b <= !(mem_req.valid && use_smm_strobe);
			normal_address_strobe_b <= !(mem_req.valid && !use_smm_strobe);
			cache_bypass <= mem_req.valid && use_smm_strobe;
			if (mem_req.valid) begin
				bus_addr <= mem_req.addr;
				if (!use_smm_strobe && gate_mask_low) begin
					bus_addr[`ADDR_LINE_TWENTY] <= 1'b0;
				end else begin
					bus_addr[`ADDR_LINE_TWENTY] <= mem_req.addr[`ADDR_LINE_TWENTY];
				end
			end
		end
	end

endmodule : smm_control

// ==== hdl/smm_ctrl_pkg.sv ====
// types shared by the smm control block
package smm_ctrl_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ENTRY = 4'b0010,
		ST_HANDLER = 4'b0100,
		ST_RESUME = 4'b1000
	} smm_state_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic is_code;
		logic cs_prefix;
	} mem_req_t;

	typedef struct packed {
		logic load;
		logic [31:0] cs_base;
		logic [15:0] cs_selector;
		logic [31:0] cs_limit;
		logic [31:0] eip;
	} seg_load_t;

	typedef struct packed {
		logic load;
		logic [31:0] next_ip_addr;
		logic restore_cs;
		logic restore_eflags;
		logic restore_cr0;
		logic restore_dr7;
	} resume_load_t;

endpackage : smm_ctrl_pkg

// ==== hdl/smm_ctrl_regs.svh ====
// offsets, field positions, reset values and fixed figures of the smm control block
`ifndef SMM_CTRL_REGS_SVH
`define SMM_CTRL_REGS_SVH

// i/o ports for index and data
`define IO_INDEX_PORT 16'h0022
`define IO_DATA_PORT 16'h0023

// configuration register indices
`define IDX_CONFIG_CONTROL_ONE 8'hC1
`define IDX_REGION4_HIGH 8'hCE
`define IDX_REGION4_LOW 8'hCF

// config_control_one fields
`define CCR_SMI_ENABLE_BIT 1
`define CCR_SMM_ACCESS_BIT 2
`define CCR_OVERLAP_BIT 3
`define CCR_REGION4_SMM_BIT 7
`define CCR_OVERLAP_MASK 8'h08
`define CCR_SETUP_MASK 8'h82

// region4_range_reg fields
`define RANGE_BASE_HI 15
`define RANGE_BASE_LO 4
`define RANGE_SIZE_HI 3
`define RANGE_SIZE_LO 0
`define RANGE_SIZE_MAX_CODE 4'hD
`define RANGE_MIN_BYTES 32'h0000_1000

// reset values
`define CONFIG_CONTROL_ONE_RESET 8'h00
`define REGION4_RANGE_RESET 16'h0000
`define IO_INDEX_RESET 8'h00

// header and entry figures
`define NEXT_IP_OFFSET 32'h0000_0014
`define ENTRY_EIP 32'h0000_0000
`define ADDR_LINE_TWENTY 20

`endif

// ==== testbench/chipset_model.sv ====
// chipset side: smi request, pin resolution and nmi latch
`timescale 1ns/1ps
module chipset_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// request from the bench
	input wire logic smi_request,
	// device pin drive
	input wire logic pin_out,
	input wire logic pin_oe,
	// resolved pin and nmi gate
	output logic smi_line_b,
	output logic nmi_blocked
);
	logic pull_low_reg;
	// hold the line low until the device takes it over
	always_ff @(posedge ref_clk) begin
		if (!rst_b) pull_low_reg <= 1'b0;
		else if (smi_request) pull_low_reg <= 1'b1;
		else if (pin_oe) pull_low_reg <= 1'b0;
	end
	// pull-up when nobody drives low
	assign smi_line_b = !(pull_low_reg || (pin_oe && !pin_out));
	always_ff @(posedge ref_clk) begin
		if (!rst_b) nmi_blocked <= 1'b0;
		else nmi_blocked <= pin_oe;
	end
endmodule : chipset_model

// ==== testbench/smm_control_assertions.sv ====
// port-level checks of the smm control block
`timescale 1ns/1ps
module smm_control_assertions import smm_ctrl_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// requests
	input wire logic io_req,
	input wire logic [15:0] io_port,
	input wire mem_req_t mem_req,
	input wire logic resume_from_mgmt,
	// answers
	input wire logic io_ack,
	input wire logic smm_address_strobe_b,
	input wire logic normal_address_strobe_b,
	input wire logic cache_bypass,
	input wire logic mgmt_interrupt_line_out,
	input wire logic mgmt_interrupt_line_oe,
	input wire logic smi_in_progress,
	input wire seg_load_t entry_load,
	input wire resume_load_t resume_load,
	input wire logic maskable_int_disable,
	input wire logic nmi_only_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	one_strobe_a: assert property (mem_req.valid |=> smm_address_strobe_b ^ normal_address_strobe_b)
		else $error("strobe choice not one-hot");
	no_strobe_a: assert property (!mem_req.valid |=> smm_address_strobe_b && normal_address_strobe_b)
		else $error("strobe without request");
	smm_uncached_a: assert property (!smm_address_strobe_b |-> cache_bypass)
		else $error("smm access not bypassing cache");
	io_answer_a: assert property (io_req && (io_port == 16'h0022 || io_port == 16'h0023) |=> io_ack)
		else $error("config port access not answered");
	progress_pin_a: assert property (smi_in_progress == mgmt_interrupt_line_oe)
		else $error("progress flag differs from pin drive");
	pin_low_a: assert property (mgmt_interrupt_line_oe |-> !mgmt_interrupt_line_out)
		else $error("driven pin not low");
	entry_ints_a: assert property ($rose(mgmt_interrupt_line_oe)
		|-> entry_load.load && maskable_int_disable && nmi_only_enable)
		else $error("entry without interrupt setup");
	entry_eip_a: assert property (entry_load.load |-> entry_load.eip == 32'h0000_0000
		&& entry_load.cs_selector == entry_load.cs_base[19:4])
		else $error("entry segment state wrong");
	hold_until_a: assert property ($fell(mgmt_interrupt_line_oe) |-> $past(resume_load.load))
		else $error("pin released without resume");
	resume_seq_a: assert property (resume_from_mgmt && mgmt_interrupt_line_oe && $past(mgmt_interrupt_line_oe)
		|=> resume_load.load ##1 !mgmt_interrupt_line_oe)
		else $error("resume not handled in time");
	restore_set_a: assert property (resume_load.load |-> resume_load.restore_cs && resume_load.restore_eflags
		&& resume_load.restore_cr0 && resume_load.restore_dr7)
		else $error("resume restore set incomplete");
endmodule : smm_control_assertions

bind smm_control smm_control_assertions i_chk (.*);

// ==== testbench/tb.sv ====
// self-checking bench of the smm control block
`timescale 1ns/1ps
`include "smm_ctrl_regs.svh"
module tb import smm_ctrl_pkg::*;;
	logic ref_clk, rst_b, io_req, io_write, io_ack, smm_address_strobe_b, normal_address_strobe_b, cache_bypass;
	logic gate_line_twenty_mask_b, mgmt_interrupt_line_in_b, mgmt_interrupt_line_out, mgmt_interrupt_line_oe;
	logic cpl_zero, smm_instr_attempt, resume_from_mgmt, eip_check, limit_write, limit_write_real_mode;
	logic maskable_int_disable, nmi_only_enable, undefined_opcode, cs_limit_fault, smi_in_progress;
	logic smi_request, nmi_blocked;
	logic [15:0] io_port;
	logic [7:0] io_wdata, io_rdata;
	logic [31:0] bus_addr, eip_now, limit_write_value;
	mem_req_t mem_req;
	seg_load_t entry_load;
	resume_load_t resume_load;
	int failures, total_checks;

	smm_control i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .io_req(io_req), .io_write(io_write), .io_port(io_port),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .mem_req(mem_req),
		.smm_address_strobe_b(smm_address_strobe_b), .normal_address_strobe_b(normal_address_strobe_b),
		.bus_addr(bus_addr), .cache_bypass(cache_bypass), .gate_line_twenty_mask_b(gate_line_twenty_mask_b),
		.mgmt_interrupt_line_in_b(mgmt_interrupt_line_in_b), .mgmt_interrupt_line_out(mgmt_interrupt_line_out),
		.mgmt_interrupt_line_oe(mgmt_interrupt_line_oe), .cpl_zero(cpl_zero), .smm_instr_attempt(smm_instr_attempt),
		.resume_from_mgmt(resume_from_mgmt), .eip_now(eip_now), .eip_check(eip_check), .limit_write(limit_write),
		.limit_write_real_mode(limit_write_real_mode), .limit_write_value(limit_write_value),
		.entry_load(entry_load), .resume_load(resume_load), .maskable_int_disable(maskable_int_disable),
		.nmi_only_enable(nmi_only_enable), .undefined_opcode(undefined_opcode), .cs_limit_fault(cs_limit_fault),
		.smi_in_progress(smi_in_progress));
	chipset_model i_chipset (.ref_clk(ref_clk), .rst_b(rst_b), .smi_request(smi_request),
		.pin_out(mgmt_interrupt_line_out), .pin_oe(mgmt_interrupt_line_oe),
		.smi_line_b(mgmt_interrupt_line_in_b), .nmi_blocked(nmi_blocked));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic io(input logic wr, input logic [15:0] p, input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk);
		io_req <= 1'b1;
		io_write <= wr;
		io_port <= p;
		io_wdata <= d;
		@(posedge ref_clk);
		io_req <= 1'b0;
		@(negedge ref_clk);
		q = io_rdata;
		check(io_ack, 1'b1);
	endtask : io

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [7:0] q;
		io(1'b1, `IO_INDEX_PORT, idx, q);
		io(1'b1, `IO_DATA_PORT, v, q);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		io(1'b1, `IO_INDEX_PORT, idx, q);
		io(1'b0, `IO_DATA_PORT, 8'h00, q);
		check(q, exp);
	endtask : rd

	task automatic mem(input logic [31:0] a, input logic code, input logic pfx, input logic smm);
		@(posedge ref_clk);
		mem_req <= '{1'b1, a, code, pfx};
		@(posedge ref_clk);
		mem_req.valid <= 1'b0;
		@(negedge ref_clk);
		check({smm_address_strobe_b, normal_address_strobe_b, cache_bypass}, smm ? 3'b011 : 3'b100);
	endtask : mem

	task automatic instr(input logic exp);
		@(posedge ref_clk);
		smm_instr_attempt <= 1'b1;
		@(posedge ref_clk);
		smm_instr_attempt <= 1'b0;
		@(negedge ref_clk);
		check(undefined_opcode, exp);
	endtask : instr

	task automatic eipc(input logic [31:0] e, input logic exp);
		@(posedge ref_clk);
		eip_check <= 1'b1;
		eip_now <= e;
		@(posedge ref_clk);
		eip_check <= 1'b0;
		@(negedge ref_clk);
		check(cs_limit_fault, exp);
	endtask : eipc

	task automatic t_regs;
		rd(`IDX_CONFIG_CONTROL_ONE, 8'h00);
		wr(`IDX_CONFIG_CONTROL_ONE, `CCR_SETUP_MASK);
		rd(`IDX_CONFIG_CONTROL_ONE, 8'h82);
		wr(`IDX_REGION4_HIGH, 8'h1C);
		wr(`IDX_REGION4_LOW, 8'h82);
		rd(`IDX_REGION4_HIGH, 8'h1C);
		rd(`IDX_REGION4_LOW, 8'h82);
		rd(8'h55, 8'h00);
		instr(1'b1);
		$display("regs test done");
	endtask : t_regs

	task automatic t_strobe;
		mem(32'h001C_8000, 1'b0, 1'b0, 1'b0);
		@(posedge ref_clk);
		gate_line_twenty_mask_b <= 1'b0;
		wr(`IDX_CONFIG_CONTROL_ONE, 8'h86);
		instr(1'b0);
		mem(32'h001C_9FFF, 1'b1, 1'b0, 1'b1);
		check(bus_addr, 32'h001C_9FFF);
		mem(32'h001C_A000, 1'b0, 1'b0, 1'b0);
		check(bus_addr, 32'h000C_A000);
		mem(32'h001C_7FFF, 1'b0, 1'b0, 1'b0);
		@(posedge ref_clk);
		gate_line_twenty_mask_b <= 1'b1;
		wr(`IDX_CONFIG_CONTROL_ONE, 8'h82);
		$display("strobe test done");
	endtask : t_strobe

	task automatic t_smi;
		@(posedge ref_clk);
		smi_request <= 1'b1;
		@(posedge ref_clk);
		smi_request <= 1'b0;
		repeat (10) begin
			@(negedge ref_clk);
			if (entry_load.load === 1'b1) break;
		end
		check(entry_load.load, 1'b1);
		check(mgmt_interrupt_line_out, 1'b0);
		check(maskable_int_disable & nmi_only_enable, 1'b1);
		check(entry_load.cs_base, 32'h001C_8000);
		check(entry_load.eip, `ENTRY_EIP);
		check(entry_load.cs_limit, 32'h0000_1FFF);
		check(entry_load.cs_selector, 16'hC800);
		check(smi_in_progress, 1'b1);
		instr(1'b0);
		check(nmi_blocked, 1'b1);
		@(posedge ref_clk);
		cpl_zero <= 1'b0;
		instr(1'b1);
		@(posedge ref_clk);
		cpl_zero <= 1'b1;
		wr(`IDX_CONFIG_CONTROL_ONE, 8'h8A);
		mem(32'h001C_8010, 1'b0, 1'b0, 1'b0);
		mem(32'h001C_8010, 1'b0, 1'b1, 1'b1);
		mem(32'h001C_8010, 1'b1, 1'b0, 1'b1);
		eipc(32'h0000_1FFF, 1'b0);
		eipc(32'h0000_2000, 1'b1);
		@(posedge ref_clk);
		limit_write <= 1'b1;
		limit_write_real_mode <= 1'b1;
		limit_write_value <= 32'hFFFF_FFFF;
		@(posedge ref_clk);
		limit_write <= 1'b0;
		eipc(32'h0000_2000, 1'b1);
		@(posedge ref_clk);
		resume_from_mgmt <= 1'b1;
		@(posedge ref_clk);
		resume_from_mgmt <= 1'b0;
		@(negedge ref_clk);
		check(resume_load.load, 1'b1);
		check(resume_load.next_ip_addr, 32'h001C_9FEC);
		check({resume_load.restore_cs, resume_load.restore_eflags, resume_load.restore_cr0,
			resume_load.restore_dr7}, 4'hF);
		@(negedge ref_clk);
		check(smi_in_progress, 1'b0);
		instr(1'b1);
		check(nmi_blocked, 1'b0);
		$display("smi test done");
	endtask : t_smi

	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	initial begin
		#50000;
		failures++;
		conclude;
	end

	initial begin
		rst_b = 1'b0;
		{io_req, io_write, smm_instr_attempt, resume_from_mgmt, eip_check, limit_write} = '0;
		{limit_write_real_mode, smi_request} = '0;
		io_port = 16'h0000;
		io_wdata = 8'h00;
		eip_now = 32'h0000_0000;
		limit_write_value = 32'h0000_0000;
		mem_req = '0;
		gate_line_twenty_mask_b = 1'b1;
		cpl_zero = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_regs();
		t_strobe();
		t_smi();
		conclude;
	end
endmodule : tb
